// File: src/ehsf_pkg.sv
// Package: offsets, bit positions and carrier structs for the status flags
package ehsf_pkg;

  localparam logic [7:0] STS_OFFSET = 8'h24;
  localparam logic [7:0] CMD_OFFSET = 8'h20;
  localparam logic [7:0] INTR_OFFSET = 8'h28;

  // Status flag positions
  localparam int DONE_BIT = 0;
  localparam int TERR_BIT = 1;
  localparam int PCHG_BIT = 2;
  localparam int ROLL_BIT = 3;
  localparam int HSE_BIT = 4;
  localparam int IAA_BIT = 5;
  localparam int NUM_FLAGS = 6;

  // Command register bit positions
  localparam int RUN_STOP_POS = 0;
  localparam int FLS_LO_POS = 2;
  localparam int DOORBELL_POS = 6;

  // Frame list size codes and the index bit watched for each
  localparam logic [1:0] FLS_1024 = 2'h0;
  localparam logic [1:0] FLS_512 = 2'h1;
  localparam logic [1:0] FLS_256 = 2'h2;
  localparam int FIDX_BIT_1024 = 13;
  localparam int FIDX_BIT_512 = 12;
  localparam int FIDX_BIT_256 = 11;
  localparam int FIDX_W = 14;

  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // Events reported by the schedule engine in one cycle
  typedef struct packed {
    logic async_advanced;
    logic td_retired;
    logic td_ioc;
    logic td_error;
    logic short_packet;
  } ehsf_sched_t;

  // Serious host access failures seen by the bus master
  typedef struct packed {
    logic parity_err;
    logic master_abort;
    logic target_abort;
  } ehsf_sys_err_t;

  // Register write strobe with data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } ehsf_reg_wr_t;

endpackage

// File: src/ehsf_status_flags.sv
// Low-order host status flags with write-one-to-clear and interrupt gating
// How it works
// - Doorbell then async advance sets bit 5
// - Parity or abort failure sets bit 4
// - System error clears the run/stop bit
// - Frame index wrap sets bit 3
// - Wrap watched on index bit 13/12/11
// - Unowned port change sets bit 2
// - Force resume rising also sets bit 2
// - D3-to-D0 loads bit 2 from change OR
// - Transaction error sets bit 1
// - Retired error with interrupt-on-complete sets both
// - Retired descriptor with interrupt-on-complete sets bit 0
// - Short packet also sets bit 0
// - Writing one clears, zero keeps
// - Interrupt when flag and enable set
module ehsf_status_flags #(
  parameter int NUM_PORTS = 2
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire ehsf_pkg::ehsf_reg_wr_t i_reg_wr,
  input wire logic [ehsf_pkg::FIDX_W-1:0] i_frame_index,
  input wire ehsf_pkg::ehsf_sched_t i_sched,
  input wire ehsf_pkg::ehsf_sys_err_t i_sys_err,
  input wire logic [NUM_PORTS-1:0] i_port_owner,
  input wire logic [NUM_PORTS-1:0] i_port_change,
  input wire logic [NUM_PORTS-1:0] i_force_resume,
  input wire logic i_d3_to_d0,
  input wire logic [5:0] i_intr_enable,
  output logic [31:0] o_status,
  output logic o_run_stop,
  output logic o_doorbell,
  output logic [1:0] o_frame_list_size,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Write decode

  // Shared by every register that this block owns
  function automatic logic wr_hits(input ehsf_pkg::ehsf_reg_wr_t w,
                                   input logic [7:0] offset);
    return w.wr && (w.addr == offset);
  endfunction

  logic sts_wr;
  logic cmd_wr;
  logic [5:0] clear_mask;
  assign sts_wr = wr_hits(i_reg_wr, ehsf_pkg::STS_OFFSET);
  assign cmd_wr = wr_hits(i_reg_wr, ehsf_pkg::CMD_OFFSET);
  assign clear_mask = sts_wr ? i_reg_wr.data[5:0] : 6'h00;

  ////////////////////////////////////////////////////////////////////////
  // Event detection

  logic sys_err;
  logic roll_evt;
  logic watch_bit;
  logic watch_bit_r;
  logic pchg_evt;
  logic [NUM_PORTS-1:0] chg_r;
  logic [NUM_PORTS-1:0] fpr_r;
  logic [NUM_PORTS-1:0] port_evt;
  logic [1:0] fls_seen_r;
  logic iaa_evt;
  logic [5:0] set_mask;

  assign sys_err = |i_sys_err;

  // Index bit chosen by list size; any toggle while the size is unchanged means a wrap
  always_comb begin
    unique case (o_frame_list_size)
      ehsf_pkg::FLS_1024: watch_bit = i_frame_index[ehsf_pkg::FIDX_BIT_1024];
      ehsf_pkg::FLS_512: watch_bit = i_frame_index[ehsf_pkg::FIDX_BIT_512];
      default: watch_bit = i_frame_index[ehsf_pkg::FIDX_BIT_256];
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      watch_bit_r <= 1'b0;
    end else begin
      watch_bit_r <= watch_bit;
    end
  end

  // Remembers the size that watch_bit_r was taken under
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      fls_seen_r <= ehsf_pkg::FLS_1024;
    end else begin
      fls_seen_r <= o_frame_list_size;
    end
  end

  // A size change swaps the watched bit; that step is not a wrap, so the
  // compare is skipped for the one cycle in which old and new sizes differ
  assign roll_evt = (watch_bit ^ watch_bit_r)
                  && (o_frame_list_size == fls_seen_r);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      chg_r <= '0;
      fpr_r <= '0;
    end else begin
      chg_r <= i_port_change;
      fpr_r <= i_force_resume;
    end
  end

  // One detector per port; an owned port belongs to the companion
  // controller, so its change bits stay out of this flag except on a D3-to-D0 load
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign port_evt[gp] = (i_port_change[gp] && !chg_r[gp]
                            && !i_port_owner[gp])
                          || (i_force_resume[gp] && !fpr_r[gp]);
    end
  endgenerate

  assign pchg_evt = |port_evt;

  assign iaa_evt = o_doorbell && i_sched.async_advanced;

  always_comb begin
    set_mask = 6'h00;
    set_mask[ehsf_pkg::IAA_BIT] = iaa_evt;
    set_mask[ehsf_pkg::HSE_BIT] = sys_err;
    set_mask[ehsf_pkg::ROLL_BIT] = roll_evt;
    set_mask[ehsf_pkg::PCHG_BIT] = pchg_evt;
    set_mask[ehsf_pkg::TERR_BIT] = i_sched.td_error;
    set_mask[ehsf_pkg::DONE_BIT] =
      (i_sched.td_retired && i_sched.td_ioc)
      || i_sched.short_packet;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over a clear in the same cycle

  logic [5:0] flags_r;
  logic [5:0] flags_nxt;

  always_comb begin
    flags_nxt = (flags_r & ~clear_mask) | set_mask;
    if (i_d3_to_d0) begin
      flags_nxt[ehsf_pkg::PCHG_BIT] = |i_port_change;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      flags_r <= ehsf_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      o_status <= 32'h0000_0000;
    end else begin
      o_status <= {26'h000_0000, flags_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command bits owned jointly with software

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      o_run_stop <= 1'b0;
    end else if (sys_err) begin
      o_run_stop <= 1'b0;
    end else if (cmd_wr) begin
      o_run_stop <= i_reg_wr.data[ehsf_pkg::RUN_STOP_POS];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      o_frame_list_size <= ehsf_pkg::FLS_1024;
    end else if (cmd_wr) begin
      o_frame_list_size <=
        i_reg_wr.data[ehsf_pkg::FLS_LO_POS +: 2];
    end
  end

  // Writing zero to the doorbell never cancels a pending request
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      o_doorbell <= 1'b0;
    end else if (iaa_evt) begin
      o_doorbell <= 1'b0;
    end else if (cmd_wr && i_reg_wr.data[ehsf_pkg::DOORBELL_POS]) begin
      o_doorbell <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags_nxt & i_intr_enable);
    end
  end

endmodule

// File: verif/ehsf_status_flags_chk.sv
// Checker: status flag timing seen at the block's ports
module ehsf_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire ehsf_pkg::ehsf_reg_wr_t i_reg_wr,
  input wire ehsf_pkg::ehsf_sched_t i_sched,
  input wire ehsf_pkg::ehsf_sys_err_t i_sys_err,
  input wire logic i_d3_to_d0,
  input wire logic [5:0] i_intr_enable,
  input wire logic [31:0] o_status,
  input wire logic o_run_stop,
  input wire logic o_doorbell,
  input wire logic o_irq
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_ring; o_doorbell && i_sched.async_advanced; endsequence
  a_iaa_set: assert property (s_ring
    |=> o_status[5] && !o_doorbell) else $error("iaa");
  a_db_hold: assert property (o_doorbell
    && !i_sched.async_advanced && !i_reg_wr.wr && !i_sys_err
    |=> o_doorbell) else $error("doorbell");
  a_hse_set: assert property (|i_sys_err
    |=> o_status[4] && !o_run_stop) else $error("hse");
  a_done_set: assert property (i_sched.short_packet
    || i_sched.td_retired && i_sched.td_ioc |=> o_status[0])
    else $error("done");
  a_err_set: assert property (i_sched.td_error
    |=> o_status[1]) else $error("error");
  a_irq_gate: assert property (
    o_irq == |(o_status[5:0] & $past(i_intr_enable))) else $error("irq");
  a_flag_keep: assert property (!i_d3_to_d0 && !(i_reg_wr.wr
    && i_reg_wr.addr == ehsf_pkg::STS_OFFSET)
    |=> ($past(o_status[5:0]) & ~o_status[5:0]) == 6'h00)
    else $error("flag lost");
  a_upper_zero: assert property (
    o_status[31:6] == 26'h0000000) else $error("reserved");
endmodule

bind ehsf_status_flags ehsf_chk u_chk (.*);

// File: verif/ehsf_host_model.sv
// Host software model: register writes into the flag block
module ehsf_host_model (
  input wire logic i_clk,
  output ehsf_pkg::ehsf_reg_wr_t o_reg_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_reg_wr = '0;
  // Released fields show their inverse so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    o_reg_wr = '{1'b1, a, d};
    @(negedge i_clk);
    o_reg_wr = '{1'b0, ~a, ~d};
  endtask
endmodule

// File: verif/tb.sv
// Testbench: status flag sets, clears and interrupt gating
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, d3 = 1'b0, rs, db, irq;
  ehsf_pkg::ehsf_reg_wr_t wr;
  ehsf_pkg::ehsf_sched_t sc = '0;
  ehsf_pkg::ehsf_sys_err_t se = '0;
  logic [13:0] fi = 14'h0000;
  logic [1:0] own = 2'h2, chg = 2'h0, force_port_resume_bit = 2'h0;
  logic [5:0] en = 6'h00;
  logic [31:0] st;
  logic [1:0] frame_list_size_field;
  wire [8:0] obs = {irq, rs, db, st[5:0]};
  logic [4:0] tv [6] = '{5'h02, 5'h0E, 5'h0C, 5'h01, 5'h08, 5'h04};
  logic [5:0] tf [6] = '{6'h02, 6'h03, 6'h01, 6'h01, 6'h00, 6'h00};
  int n_errors = 0, compares = 0;
  always #2 clk = ~clk;
  ehsf_host_model u_sw (.i_clk(clk), .o_reg_wr(wr));
  ehsf_status_flags u_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst),
    .i_reg_wr(wr), .i_frame_index(fi), .i_sched(sc), .i_sys_err(se),
    .i_port_owner(own), .i_port_change(chg), .i_force_resume(force_port_resume_bit),
    .i_d3_to_d0(d3), .i_intr_enable(en), .o_status(st), .o_run_stop(rs),
    .o_doorbell(db), .o_frame_list_size(frame_list_size_field), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] got,
    input logic [8:0] e);
    compares++;
    if (got !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, got);
    end
  endtask
  // One-cycle pulses; with no arguments this is a plain cycle
  task automatic ev(logic [4:0] s = 0, logic [2:0] e = 0, logic d = 0);
    sc = s;
    se = e;
    d3 = d;
    @(negedge clk);
    sc = '0;
    se = '0;
    d3 = 1'b0;
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #10us;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("reset", obs, 9'h000);
    chk("reset size", {7'h00, frame_list_size_field}, 9'h000);
    u_sw.wr(8'h20, 32'h41);
    ev(5'h10);
    chk("advance", obs, 9'h0A0);
    en = 6'h20;
    ev();
    chk("irq", obs, 9'h1A0);
    u_sw.wr(8'h24, 32'h0);
    chk("keep", obs, 9'h1A0);
    u_sw.wr(8'h24, 32'h20);
    chk("clear", obs, 9'h080);
    en = 6'h3F;
    for (int i = 0; i < 3; i++) begin
      ev(5'h00, 3'(1 << i));
      chk("sys err", obs, 9'h110);
      u_sw.wr(8'h24, 32'h10);
      u_sw.wr(8'h20, 32'h1);
    end
    fi = 14'h2000;
    ev();
    chk("wrap 1024", obs, 9'h188);
    u_sw.wr(8'h20, 32'h5);
    chk("list size", {7'h00, frame_list_size_field}, 9'h001);
    u_sw.wr(8'h24, 32'h8);
    fi = 14'h3000;
    ev();
    chk("wrap 512", obs, 9'h188);
    u_sw.wr(8'h24, 32'h8);
    fi = 14'h1000;
    chg = 2'h2;
    ev();
    chk("owned port", obs, 9'h080);
    ev(5'h00, 3'h0, 1'b1);
    chk("wake load", obs, 9'h184);
    chg = 2'h0;
    ev(5'h00, 3'h0, 1'b1);
    chk("wake zero", obs, 9'h080);
    chg = 2'h1;
    ev();
    chk("port", obs, 9'h184);
    u_sw.wr(8'h24, 32'h4);
    force_port_resume_bit = 2'h2;
    ev();
    chk("resume", obs, 9'h184);
    u_sw.wr(8'h24, 32'h4);
    for (int i = 0; i < 6; i++) begin
      ev(tv[i]);
      chk("sched", obs, {|tf[i], 2'h2, tf[i]});
      u_sw.wr(8'h24, 32'h3F);
    end
    finish_test();
  end
endmodule
